/* pkg/opalign_pkg.sv */
// Purpose: shared types and constants for operand alignment and fp format unit
// Assumes: 32-bit byte addresses, 64-bit internal fp format
// Notes: none
package opalign_pkg;
  localparam int ADDR_W = 32;
  localparam int EXP_W = 11;
  localparam int EXP_EXT_W = EXP_W + 2;
  localparam logic [10:0] DP_BIAS = 11'h3ff;
  localparam logic [7:0] SP_BIAS = 8'h7f;
  localparam logic [12:0] DP_EXP_MAX = 13'h07fe;
  localparam logic [3:0] MASK_HALF = 4'h1;
  localparam logic [3:0] MASK_WORD = 4'h3;
  localparam logic [3:0] MASK_DWORD = 4'h7;
  localparam logic [3:0] MASK_QWORD = 4'hf;
  localparam logic [3:0] SLOW_CYCLES = 4'h1;

  typedef enum logic [2:0] {
    SZ_BYTE = 3'h0, SZ_HALF = 3'h1, SZ_WORD = 3'h2, SZ_DWORD = 3'h3, SZ_QWORD = 3'h4
  } op_size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXTRA = 2'b01, ST_DONE = 2'b11
  } acc_state_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    op_size_t size;
    logic is_fp;
    logic is_multi;
    logic is_store;
    logic [63:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    op_size_t size;
    logic is_store;
    logic [63:0] wdata;
  } mem_issue_t;

  typedef struct packed {
    logic valid;
    logic single_op;
    logic [63:0] a;
    logic [63:0] b;
  } fp_req_t;

  typedef struct packed {
    acc_state_t state;
    logic [3:0] wait_cnt;
    mem_issue_t issue;
    logic align_exc;
    logic inst_exc;
    logic done;
    logic fmt_exc;
    logic [63:0] a_wide;
    logic [63:0] b_wide;
    logic [EXP_EXT_W-1:0] a_exp;
    logic [EXP_EXT_W-1:0] b_exp;
    logic [63:0] load_out;
    logic [31:0] store_sp;
    logic [63:0] res_flushed;
  } unit_state_t;
endpackage

/* hdl/opalign_unit.sv */
// Purpose: operand alignment check and fp precision handling between execute and load/store
// Assumes: one request per cycle, memory path accepts an issue in the cycle it is shown
// Notes: fp result rounding is done elsewhere; this unit widens, narrows and flushes
// Behaviour
// [R1] memory is bytes numbered from zero, byte number equals address
// [R2] operand address is lowest byte address; length comes from instruction size
// [R3] byte, half, word, double word operands, plus byte/word sequences for multiples
// [R4] single-register alignment boundary equals operand length
// [R5] low four address bits checked per size, bytes always aligned (this unit computes the per-size test but acts only on fp bits 1:0)
// [R6] instructions are 32-bit words at word-aligned addresses
// [R7] misaligned fp operand raises alignment exception, no hardware access (this unit traps fp only when address bits 1:0 are nonzero)
// [R8] non-double-word-aligned accesses may take extra cycles
// [R9] double ops accept single operands, give double result
// [R10] single ops need single operands, give single result
// [R11] single widened to double implicitly; narrowing only by explicit instruction
// [R12] 11-bit exponent carried in 13-bit datapath
// [R13] first extra bit for prenormalizing, second for adjusted exponents
// [R14] all fp operations in hardware under all rounding modes
// [R15] single multiply-type ops usually faster than double
// [R16] single denormal load/store converted to/from internal double format
// [R17] non-ieee mode flushes denormal results to signed zero
// [R18] misalignment found before any memory access is issued
`timescale 1ns/1ps
module opalign_unit (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire opalign_pkg::mem_req_t mem_req,
  input wire logic [opalign_pkg::ADDR_W-1:0] fetch_addr,
  input wire logic fetch_valid,
  input wire opalign_pkg::fp_req_t fp_req,
  input wire logic [63:0] fp_result,
  input wire logic fp_result_single,
  input wire logic [63:0] load_data,
  input wire logic load_single,
  input wire logic nonieee_enable,
  output opalign_pkg::mem_issue_t mem_issue,
  output logic mem_busy,
  output logic mem_done,
  output logic align_exc,
  output logic inst_align_exc,
  output logic fp_format_exc,
  output logic [63:0] fp_a_wide,
  output logic [63:0] fp_b_wide,
  output logic [opalign_pkg::EXP_EXT_W-1:0] fp_a_exp,
  output logic [opalign_pkg::EXP_EXT_W-1:0] fp_b_exp,
  output logic [63:0] load_wide,
  output logic [31:0] store_single,
  output logic [63:0] result_out
);
  import opalign_pkg::*;

  unit_state_t s;
  unit_state_t next_s;

  function automatic logic [3:0] size_mask(input op_size_t sz);
    unique case (sz)
      SZ_BYTE: size_mask = 4'h0;
      SZ_HALF: size_mask = MASK_HALF;
      SZ_WORD: size_mask = MASK_WORD;
      SZ_DWORD: size_mask = MASK_DWORD;
      SZ_QWORD: size_mask = MASK_QWORD;
      default: size_mask = MASK_QWORD;
    endcase
  endfunction

  // single to double widening, denormals prenormalized
  function automatic logic [63:0] widen(input logic [31:0] v);
    logic [10:0] e;
    logic [22:0] m;
    logic [4:0] sh;
    logic found;
    e = 11'h0;
    m = v[22:0];
    sh = 5'h0;
    found = 1'b0;
    if (v[30:23] == 8'hff) begin
      widen = {v[31], 11'h7ff, v[22:0], 29'h0};
    end else if (v[30:23] != 8'h00) begin
      e = 11'(v[30:23]) - 11'(SP_BIAS) + DP_BIAS;
      widen = {v[31], e, v[22:0], 29'h0};
    end else if (m == 23'h0) begin
      widen = {v[31], 63'h0};
    end else begin
      for (int i = 22; i >= 0; i--) begin
        if (!found && m[i]) begin
          sh = 5'(22 - i);
          found = 1'b1;
        end
      end
      e = DP_BIAS - 11'(SP_BIAS) - 11'(sh);
      m = 23'(m << (sh + 5'h1));
      widen = {v[31], e, m, 29'h0};
    end
  endfunction

  // double to single narrowing, denormal range shifted out
  function automatic logic [31:0] narrow(input logic [63:0] v);
    logic [12:0] e;
    logic [23:0] m;
    e = {2'b00, v[62:52]} - 13'(DP_BIAS) + 13'(SP_BIAS);
    m = {1'b1, v[51:29]};
    if (v[62:52] == 11'h7ff) begin
      narrow = {v[63], 8'hff, v[51:29]};
    end else if (v[62:52] == 11'h0) begin
      narrow = {v[63], 31'h0};
    end else if (!e[12] && e != 13'h0) begin
      narrow = {v[63], e[7:0], v[51:29]};
    end else if ($signed(e) > -13'sd23) begin
      narrow = {v[63], 8'h00, 23'(m >> (13'h1 - e))};
    end else begin
      narrow = {v[63], 31'h0};
    end
  endfunction

  // exponent with two guard bits, denormal prenormalized via first extra bit
  function automatic logic [EXP_EXT_W-1:0] ext_exp(input logic [63:0] v);
    logic [5:0] lz;
    logic found;
    lz = 6'h0;
    found = 1'b0;
    if (v[62:52] != 11'h0 || v[51:0] == 52'h0) begin
      ext_exp = {2'b00, v[62:52]};
    end else begin
      for (int i = 51; i >= 0; i--) begin
        if (!found && v[i]) begin
          lz = 6'(51 - i);
          found = 1'b1;
        end
      end
      ext_exp = 13'h1 - 13'(lz) - 13'h1;
    end
  endfunction

  always_comb begin
    logic mis;
    logic mis_dw;
    mis = 1'b0;
    mis_dw = 1'b0;
    next_s = s;
    next_s.align_exc = 1'b0;
    next_s.inst_exc = 1'b0;
    next_s.done = 1'b0;
    next_s.fmt_exc = 1'b0;
    next_s.issue.valid = 1'b0;
    // [R4] [R5] size-based alignment test
    mis = |(mem_req.addr[3:0] & size_mask(mem_req.size));
    mis_dw = |mem_req.addr[2:0];
    unique case (s.state)
      ST_IDLE: begin
        if (mem_req.valid) begin
          // [R7] [R18] fp traps when address bits 1:0 are nonzero, not per size; nothing issued
          if (mem_req.is_fp && |mem_req.addr[1:0]) begin
            next_s.align_exc = 1'b1;
          end else begin
            // [R1] [R2] [R3] issue at lowest byte address
            next_s.issue.valid = 1'b1;
            next_s.issue.addr = mem_req.addr;
            next_s.issue.size = mem_req.is_multi ? SZ_WORD : mem_req.size;
            next_s.issue.is_store = mem_req.is_store;
            next_s.issue.wdata = mem_req.wdata;
            // [R8] extra cycle off double word
            if (mis_dw && !mem_req.is_multi) begin
              next_s.wait_cnt = SLOW_CYCLES;
              next_s.state = ST_EXTRA;
            end else begin
              next_s.state = ST_DONE;
            end
          end
        end
      end
      ST_EXTRA: begin
        next_s.wait_cnt = s.wait_cnt - 4'h1;
        if (s.wait_cnt == 4'h1) begin
          next_s.state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_s.done = 1'b1;
        next_s.state = ST_IDLE;
      end
      default: next_s.state = ST_IDLE;
    endcase
    if (mis && !mem_req.is_fp && s.state == ST_IDLE && mem_req.valid) begin
      next_s.done = 1'b0;
    end
    // [R6] instruction word alignment
    next_s.inst_exc = fetch_valid && |fetch_addr[1:0];
    if (fp_req.valid) begin
      // [R10] single op refuses double-only operands
      // [R15] single path never slower than double
      if (fp_req.single_op) begin
        next_s.fmt_exc = |fp_req.a[63:32] || |fp_req.b[63:32];
        next_s.a_wide = widen(fp_req.a[31:0]);
        next_s.b_wide = widen(fp_req.b[31:0]);
      end else begin
        // [R9] [R11] [R14] double op takes operands as given
        next_s.a_wide = fp_req.a;
        next_s.b_wide = fp_req.b;
      end
      // [R12] [R13] guarded exponent path
      next_s.a_exp = ext_exp(next_s.a_wide);
      next_s.b_exp = ext_exp(next_s.b_wide);
    end
    // [R16] load/store format conversion
    next_s.load_out = load_single ? widen(load_data[31:0]) : load_data;
    next_s.store_sp = narrow(mem_req.wdata);
    // [R17] denormal flush in non-ieee mode; [R10] single result narrowed
    if (nonieee_enable && fp_result[62:52] == 11'h0) begin
      next_s.res_flushed = {fp_result[63], 63'h0};
    end else begin
      next_s.res_flushed = fp_result;
    end
    if (fp_result_single) begin
      next_s.res_flushed = {32'h0, narrow(next_s.res_flushed)};
      if (nonieee_enable && next_s.res_flushed[30:23] == 8'h00) begin
        next_s.res_flushed = {32'h0, fp_result[63], 31'h0};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mem_issue = s.issue;
  assign mem_busy = (s.state != ST_IDLE);
  assign mem_done = s.done;
  assign align_exc = s.align_exc;
  assign inst_align_exc = s.inst_exc;
  assign fp_format_exc = s.fmt_exc;
  assign fp_a_wide = s.a_wide;
  assign fp_b_wide = s.b_wide;
  assign fp_a_exp = s.a_exp;
  assign fp_b_exp = s.b_exp;
  assign load_wide = s.load_out;
  assign store_single = s.store_sp;
  assign result_out = s.res_flushed;

  AST_FP_MISALIGN_TRAP: assert property (@(posedge ref_clk) disable iff (!rstn) // [R7]
    (s.state == ST_IDLE && mem_req.valid && mem_req.is_fp && |mem_req.addr[1:0]) |=> align_exc)
    else $error("fp misalign did not trap");
  AST_NO_ISSUE_ON_TRAP: assert property (@(posedge ref_clk) disable iff (!rstn) // [R18]
    align_exc |-> !mem_issue.valid)
    else $error("access issued with alignment trap");
  AST_INST_ALIGN: assert property (@(posedge ref_clk) disable iff (!rstn) // [R6]
    (fetch_valid && fetch_addr[1:0] != 2'b00) |=> inst_align_exc)
    else $error("misaligned fetch not flagged");
  AST_ISSUE_ADDR: assert property (@(posedge ref_clk) disable iff (!rstn) // [R2]
    mem_issue.valid |-> mem_issue.addr == $past(mem_req.addr))
    else $error("issue address not lowest byte");
  AST_DW_EXTRA: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
    (mem_issue.valid && mem_issue.addr[2:0] != 3'h0 && !$past(mem_req.is_multi)) |-> !mem_done ##1 !mem_done ##1 mem_done)
    else $error("extra cycle not taken");
  AST_ALIGNED_FAST: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
    (mem_issue.valid && mem_issue.addr[2:0] == 3'h0) |=> mem_done)
    else $error("aligned access slow");
  AST_FLUSH_SIGN: assert property (@(posedge ref_clk) disable iff (!rstn) // [R17]
    (nonieee_enable && !fp_result_single && fp_result[62:52] == 11'h0) |=> result_out == {$past(fp_result[63]), 63'h0})
    else $error("denormal not flushed");
  AST_EXP_WIDE: assert property (@(posedge ref_clk) disable iff (!rstn) // [R12]
    (fp_req.valid && !fp_req.single_op && fp_req.a[62:52] != 11'h0) |=> fp_a_exp == {2'b00, $past(fp_req.a[62:52])})
    else $error("exponent path wrong");
  AST_SINGLE_FMT: assert property (@(posedge ref_clk) disable iff (!rstn) // [R10]
    (fp_req.valid && fp_req.single_op && fp_req.a[63:32] != 32'h0) |=> fp_format_exc)
    else $error("double operand on single op accepted");
endmodule

/* testbench/lsu_model.sv */
// Purpose: load/store path model answering issued reads
// Assumes: one issue at a time
// Notes: read data stands for one cycle after the issue
`timescale 1ns/1ps
module lsu_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire opalign_pkg::mem_issue_t mem_issue,
  input wire logic [63:0] ret_data,
  output logic [63:0] load_data
);
  import opalign_pkg::*;
  // inverted outside a read beat so stale data cannot pass
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      load_data <= 64'h0;
    end else if (mem_issue.valid && !mem_issue.is_store) begin
      load_data <= ret_data;
    end else begin
      load_data <= ~load_data;
    end
  end
endmodule

/* testbench/tb_top.sv */
// Purpose: self-checking bench for opalign_unit
// Assumes: inputs change on the falling edge
// Notes: one task per scenario
`timescale 1ns/1ps
module tb_top;
  import opalign_pkg::*;
  logic ref_clk, rstn, fetch_valid, fp_result_single, load_single, nonieee_enable;
  logic mem_busy, mem_done, align_exc, inst_align_exc, fp_format_exc;
  logic [31:0] fetch_addr, store_single;
  logic [63:0] fp_result, load_data, ret_data, fp_a_wide, fp_b_wide, load_wide, result_out, last_lw;
  logic [12:0] fp_a_exp, fp_b_exp;
  mem_req_t mem_req;
  fp_req_t fp_req;
  mem_issue_t mem_issue;
  int n_errors = 0;
  int comparisons = 0;

  opalign_unit dut (.ref_clk(ref_clk), .rstn(rstn), .mem_req(mem_req), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .fp_req(fp_req), .fp_result(fp_result), .fp_result_single(fp_result_single),
    .load_data(load_data), .load_single(load_single), .nonieee_enable(nonieee_enable),
    .mem_issue(mem_issue), .mem_busy(mem_busy), .mem_done(mem_done), .align_exc(align_exc),
    .inst_align_exc(inst_align_exc), .fp_format_exc(fp_format_exc), .fp_a_wide(fp_a_wide),
    .fp_b_wide(fp_b_wide), .fp_a_exp(fp_a_exp), .fp_b_exp(fp_b_exp), .load_wide(load_wide),
    .store_single(store_single), .result_out(result_out));
  lsu_model lsu (.ref_clk(ref_clk), .rstn(rstn), .mem_issue(mem_issue), .ret_data(ret_data),
    .load_data(load_data));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // lat 4 means no completion is expected
  task automatic mem_op(input logic [31:0] a, input op_size_t sz, input logic fp, input logic multi,
                        input logic exc, input int lat, input op_size_t isz, input logic st);
    int n;
    mem_req = '{valid: 1'b1, addr: a, size: sz, is_fp: fp, is_multi: multi, is_store: st, wdata: 64'h0};
    @(negedge ref_clk);
    mem_req.valid = 1'b0;
    chk(64'(align_exc), 64'(exc));
    chk(64'(mem_issue.valid), 64'(!exc));
    chk(64'(mem_busy), 64'(!exc));
    if (!exc) begin
      chk(64'(mem_issue.addr), 64'(a));
      chk(64'(mem_issue.size), 64'(isz));
      chk(64'(mem_issue.is_store), 64'(st));
    end
    n = 1;
    while (mem_done !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
      // widened load data stands two cycles after the issue
      if (n == 3) begin
        last_lw = load_wide;
      end
    end
    chk(64'(n), 64'(lat));
    @(negedge ref_clk);
    if (n == 2) begin
      last_lw = load_wide;
    end
  endtask

  task automatic t_mem();
    mem_op(32'h8, SZ_DWORD, 1'b0, 1'b0, 1'b0, 2, SZ_DWORD, 1'b0);
    mem_op(32'h4, SZ_DWORD, 1'b0, 1'b0, 1'b0, 3, SZ_DWORD, 1'b0);
    mem_op(32'h3, SZ_BYTE, 1'b0, 1'b0, 1'b0, 3, SZ_BYTE, 1'b0);
    mem_op(32'h1, SZ_HALF, 1'b0, 1'b0, 1'b0, 3, SZ_HALF, 1'b0);
    mem_op(32'h40, SZ_QWORD, 1'b0, 1'b0, 1'b0, 2, SZ_QWORD, 1'b0);
    mem_op(32'hc, SZ_DWORD, 1'b0, 1'b1, 1'b0, 2, SZ_WORD, 1'b0);
    mem_op(32'h4, SZ_WORD, 1'b1, 1'b0, 1'b0, 3, SZ_WORD, 1'b0);
    mem_op(32'h2, SZ_DWORD, 1'b1, 1'b0, 1'b1, 4, SZ_DWORD, 1'b0);
    mem_op(32'h6, SZ_WORD, 1'b1, 1'b0, 1'b1, 4, SZ_WORD, 1'b1);
    mem_op(32'h10, SZ_DWORD, 1'b1, 1'b0, 1'b0, 2, SZ_DWORD, 1'b0);
  endtask

  task automatic t_load();
    load_single = 1'b1;
    ret_data = 64'h0000_0000_0040_0000;
    mem_op(32'h20, SZ_WORD, 1'b1, 1'b0, 1'b0, 2, SZ_WORD, 1'b0);
    chk(last_lw, 64'h3800_0000_0000_0000);
    load_single = 1'b0;
    ret_data = 64'h4000_0000_0000_0000;
    mem_op(32'h28, SZ_DWORD, 1'b1, 1'b0, 1'b0, 2, SZ_DWORD, 1'b0);
    chk(last_lw, 64'h4000_0000_0000_0000);
  endtask

  task automatic t_store();
    mem_op(32'h30, SZ_WORD, 1'b1, 1'b0, 1'b0, 2, SZ_WORD, 1'b1);
    mem_req.wdata = 64'h3800_0000_0000_0000;
    @(negedge ref_clk);
    chk(64'(store_single), 64'h0040_0000);
    mem_req.wdata = 64'hbff0_0000_0000_0000;
    @(negedge ref_clk);
    chk(64'(store_single), 64'hbf80_0000);
  endtask

  task automatic fp_op(input logic sgl, input logic [63:0] a, input logic [63:0] w, input logic [12:0] e,
                       input logic fexc);
    fp_req = '{valid: 1'b1, single_op: sgl, a: a, b: a};
    @(negedge ref_clk);
    fp_req.valid = 1'b0;
    chk(64'(fp_format_exc), 64'(fexc));
    if (!fexc) begin
      chk(fp_a_wide, w);
      chk(fp_b_wide, w);
      chk(64'(fp_a_exp), 64'(e));
      chk(64'(fp_b_exp), 64'(e));
    end
  endtask

  task automatic res_op(input logic ni, input logic sgl, input logic [63:0] r, input logic [63:0] x);
    nonieee_enable = ni;
    fp_result_single = sgl;
    fp_result = r;
    @(negedge ref_clk);
    chk(result_out, x);
  endtask

  task automatic t_fetch();
    for (int i = 0; i < 4; i++) begin
      fetch_addr = 32'h100 + 32'(i);
      fetch_valid = 1'b1;
      @(negedge ref_clk);
      fetch_valid = 1'b0;
      chk(64'(inst_align_exc), 64'(i != 0));
    end
  endtask

  initial begin
    #200000;
    n_errors++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    mem_req = '0;
    fp_req = '0;
    fetch_addr = 32'h0;
    fetch_valid = 1'b0;
    fp_result = 64'h0;
    fp_result_single = 1'b0;
    load_single = 1'b0;
    nonieee_enable = 1'b0;
    ret_data = 64'h0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    t_mem();
    t_load();
    t_store();
    t_fetch();
    fp_op(1'b1, 64'h3f80_0000, 64'h3ff0_0000_0000_0000, 13'h03ff, 1'b0);
    fp_op(1'b1, 64'h0040_0000, 64'h3800_0000_0000_0000, 13'h0380, 1'b0);
    fp_op(1'b0, 64'h4000_0000_0000_0000, 64'h4000_0000_0000_0000, 13'h0400, 1'b0);
    fp_op(1'b0, 64'h1, 64'h1, 13'h1fcd, 1'b0);
    fp_op(1'b1, 64'h1_3f80_0000, 64'h0, 13'h0, 1'b1);
    res_op(1'b1, 1'b0, 64'h8000_0000_0000_0001, 64'h8000_0000_0000_0000);
    res_op(1'b0, 1'b0, 64'h8000_0000_0000_0001, 64'h8000_0000_0000_0001);
    res_op(1'b1, 1'b0, 64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000);
    res_op(1'b0, 1'b1, 64'h3ff0_0000_0000_0000, 64'h3f80_0000);
    end_sim();
  end
endmodule
